// *** comparator_model.sv ***
// Comparator stand-in answering the trial codes
`timescale 1ns/1ps
module comparator_model (
   input  wire logic [9:0] dac_code,
   input  wire logic       analog_power_on,
   input  wire logic [9:0] level,
   output logic            comp_in
);
   // Unpowered it gives no real decision, so it answers the inverse
   assign comp_in = analog_power_on ? (dac_code <= level) : !(dac_code <= level);
endmodule

// *** result_formatter.sv ***
// Places a 10-bit conversion code into the two result bytes
`timescale 1ns/1ps
module result_formatter
   import sar_adc_pkg::*;
(
   input  wire logic [9:0]         raw_code,
   input  wire logic               differential,
   input  wire logic               left_justify_sel,
   output sar_adc_pkg::result_bytes_t bytes
);
   logic [9:0] code;

   // ==========================================================
   // Formatting
   // The SAR produces offset binary; flipping the top bit gives two's complement
   always_comb begin
      code = differential ? {~raw_code[9], raw_code[8:0]} : raw_code;
      if (left_justify_sel) begin
         bytes = {code, {JUSTIFY_PAD{1'b0}}};
      end else if (differential) begin
         bytes = {{JUSTIFY_PAD{code[9]}}, code};
      end else begin
         bytes = {{JUSTIFY_PAD{1'b0}}, code};
      end
   end
endmodule

// *** sar_adc_pkg.sv ***
// Shared types and constants for the SAR converter sequencer
package sar_adc_pkg;

   // ==========================================================
   // Sizes and counts
   localparam int RESULT_BITS        = 10;
   localparam int DIV_BITS           = 5;
   localparam int SEL_BITS           = 5;
   localparam int LP_TRACK_SAR_CLKS  = 3;
   localparam int JUSTIFY_PAD        = 16 - RESULT_BITS;

   // ==========================================================
   // Input select codes
   localparam logic [4:0] POS_TEMP_SENSOR = 5'h1e;
   localparam logic [4:0] POS_SUPPLY      = 5'h1f;
   localparam logic [4:0] NEG_VREF        = 5'h1e;
   localparam logic [4:0] NEG_GND         = 5'h1f;

   // ==========================================================
   // Reset, start and terminal-count values
   localparam logic [9:0]  SAR_RESET     = 10'h000;
   localparam logic [9:0]  SAR_FIRST     = 10'h200;
   localparam logic [15:0] RESULT_RESET  = 16'h0000;
   localparam logic [3:0]  BIT_IDX_TOP   = 4'h9;
   localparam logic [1:0]  TRACK_CNT_TOP = 2'h2;

   // ==========================================================
   // Start-of-conversion sources
   typedef enum logic [2:0] {
      START_SOFTWARE = 3'b000,
      START_TIMER0   = 3'b001,
      START_TIMER2   = 3'b010,
      START_TIMER1   = 3'b011,
      START_EXT_PIN  = 3'b100,
      START_TIMER3   = 3'b101
   } start_mode_t;

   // ==========================================================
   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_TRACK = 2'b01,
      ST_CONV  = 2'b10
   } seq_state_t;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic low_ovf;
      logic high_ovf;
      logic split_8bit;
   } timer_trig_t;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } result_bytes_t;

   typedef struct packed {
      logic [4:0] pos_pin;
      logic       pos_temp;
      logic       pos_supply;
      logic [4:0] neg_pin;
      logic       neg_vref;
      logic       neg_gnd;
      logic       differential;
   } mux_ctrl_t;

endpackage

// *** sar_adc_sequencer.sv ***
// Sequencer for a 10-bit successive-approximation converter
`timescale 1ns/1ps
module sar_adc_sequencer
   import sar_adc_pkg::*;
#(
   parameter int RES_BITS = 10,
   parameter int DIV_W    = 5
) (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      conv_enable,
   input  wire logic                      lowpower_track_sel,
   input  wire logic                      left_justify_sel,
   input  wire logic [DIV_W-1:0]          sar_clk_divider,
   input  wire logic [2:0]                start_source_sel,
   input  wire logic [4:0]                pos_input_select,
   input  wire logic [4:0]                neg_input_select,
   input  wire logic                      sw_start,
   input  wire logic                      done_clear,
   input  wire logic                      irq_enable,
   input  wire logic                      standby_track_off,
   input  wire logic                      timer0_ovf,
   input  wire logic                      timer1_ovf,
   input  wire sar_adc_pkg::timer_trig_t  timer2,
   input  wire sar_adc_pkg::timer_trig_t  timer3,
   input  wire logic                      ext_start_pin,
   input  wire logic                      comp_in,
   output logic                           analog_power_on,
   output logic                           track,
   output logic [RES_BITS-1:0]            dac_code,
   output sar_adc_pkg::mux_ctrl_t         mux_ctrl,
   output logic                           conv_in_progress,
   output logic                           conv_done_flag,
   output logic                           conv_irq,
   output logic [7:0]                     result_high_byte,
   output logic [7:0]                     result_low_byte
);
   // ==========================================================
   // Declarations
   seq_state_t          state;
   seq_state_t          next_state;
   logic [RES_BITS-1:0] sar;
   logic [RES_BITS-1:0] next_sar;
   logic [3:0]          bit_idx;
   logic [3:0]          next_bit_idx;
   logic [1:0]          track_cnt;
   logic [1:0]          next_track_cnt;
   logic                next_busy;
   logic                next_done_flag;
   logic                next_irq;
   logic [7:0]          next_high;
   logic [7:0]          next_low;
   logic                ext_prev;
   logic                next_ext_prev;
   logic                ext_rise;
   logic                start_event;
   logic                direct_convert;
   logic                sar_tick;
   logic                restart_div;
   logic                finish;
   logic                next_track;
   logic                next_power;
   mux_ctrl_t           next_mux;
   result_bytes_t       formatted;

   // ==========================================================
   // Helpers
   // Timer 2 and 3 share the split-mode overflow choice
   function automatic logic timer_event(input timer_trig_t t);
      timer_event = t.split_8bit ? t.low_ovf : t.high_ovf;
   endfunction

   // Pin start changes both the start path and the tracking window
   function automatic logic is_pin_start(input logic [2:0] sel);
      is_pin_start = (sel == START_EXT_PIN);
   endfunction

   // ==========================================================
   // Start source selection
   assign ext_rise = ext_start_pin & ~ext_prev;

   always_comb begin
      case (start_source_sel)
         START_SOFTWARE: start_event = sw_start;
         START_TIMER0:   start_event = timer0_ovf;
         START_TIMER2:   start_event = timer_event(timer2);
         START_TIMER1:   start_event = timer1_ovf;
         START_EXT_PIN:  start_event = ext_rise;
         START_TIMER3:   start_event = timer_event(timer3);
         default:        start_event = 1'b0;
      endcase
   end

   // Pin-started low-power conversions tracked while the pin was low
   assign direct_convert = ~lowpower_track_sel |
                           is_pin_start(start_source_sel);

   always_comb begin
      next_ext_prev = ext_start_pin;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ext_prev <= 1'b0;
      end else begin
         ext_prev <= next_ext_prev;
      end
   end

   // ==========================================================
   // Conversion clock
   assign restart_div = (state == ST_IDLE);

   sar_clk_divider_gen #(
      .DIV_BITS (DIV_W)
   ) u_div (
      .clk     (clk),
      .rst     (rst),
      .restart (restart_div),
      .divider (sar_clk_divider),
      .tick    (sar_tick)
   );

   // ==========================================================
   // Sequencer
   always_comb begin
      next_state     = state;
      next_sar       = sar;
      next_bit_idx   = bit_idx;
      next_track_cnt = track_cnt;
      finish         = 1'b0;
      case (state)
         ST_IDLE: begin
            next_sar = SAR_RESET;
            if (conv_enable && start_event) begin
               next_bit_idx   = BIT_IDX_TOP;
               next_track_cnt = '0;
               if (direct_convert) begin
                  next_state = ST_CONV;
                  next_sar   = SAR_FIRST;
               end else begin
                  next_state = ST_TRACK;
               end
            end
         end
         ST_TRACK: begin
            // Starts arriving here are dropped, not queued
            if (sar_tick) begin
               next_track_cnt = track_cnt + 2'h1;
               if (track_cnt == TRACK_CNT_TOP) begin
                  next_state = ST_CONV;
                  next_sar   = SAR_FIRST;
               end
            end
         end
         ST_CONV: begin
            if (sar_tick) begin
               next_sar[bit_idx] = comp_in;
               if (bit_idx == 4'h0) begin
                  finish     = 1'b1;
                  next_state = ST_IDLE;
               end else begin
                  next_sar[bit_idx - 4'h1] = 1'b1;
                  next_bit_idx             = bit_idx - 4'h1;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // Dropping the enable abandons any conversion underway
      if (!conv_enable) begin
         next_state = ST_IDLE;
         finish     = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state     <= ST_IDLE;
         sar       <= SAR_RESET;
         bit_idx   <= BIT_IDX_TOP;
         track_cnt <= '0;
      end else begin
         state     <= next_state;
         sar       <= next_sar;
         bit_idx   <= next_bit_idx;
         track_cnt <= next_track_cnt;
      end
   end

   assign dac_code = sar;

   // ==========================================================
   // Result formatting
   result_formatter u_fmt (
      .raw_code         (next_sar),
      .differential     (mux_ctrl.differential),
      .left_justify_sel (left_justify_sel),
      .bytes            (formatted)
   );

   // ==========================================================
   // Status and result registers
   always_comb begin
      next_busy = (next_state != ST_IDLE);
      // A completion in the clearing cycle still sets the flag
      next_done_flag = finish | (conv_done_flag & ~done_clear);
      next_irq       = next_done_flag & irq_enable;
      next_high      = result_high_byte;
      next_low       = result_low_byte;
      if (finish) begin
         next_high = formatted.high;
         next_low  = formatted.low;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         conv_in_progress <= 1'b0;
         conv_done_flag   <= 1'b0;
         conv_irq         <= 1'b0;
         result_high_byte <= RESULT_RESET[15:8];
         result_low_byte  <= RESULT_RESET[7:0];
      end else begin
         conv_in_progress <= next_busy;
         conv_done_flag   <= next_done_flag;
         conv_irq         <= next_irq;
         result_high_byte <= next_high;
         result_low_byte  <= next_low;
      end
   end

   // ==========================================================
   // Track-and-hold control
   always_comb begin
      next_track = 1'b0;
      if (conv_enable && !standby_track_off) begin
         if (!lowpower_track_sel) begin
            next_track = (next_state != ST_CONV);
         end else if (is_pin_start(start_source_sel)) begin
            next_track = (next_state == ST_IDLE) & ~ext_start_pin;
         end else begin
            next_track = (next_state == ST_TRACK);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         track <= 1'b0;
      end else begin
         track <= next_track;
      end
   end

   // ==========================================================
   // Multiplexer control
   // Registered so the switch network never sees a decode glitch
   always_comb begin
      next_mux.pos_pin      = pos_input_select;
      next_mux.pos_temp     = (pos_input_select == POS_TEMP_SENSOR);
      next_mux.pos_supply   = (pos_input_select == POS_SUPPLY);
      next_mux.neg_pin      = neg_input_select;
      next_mux.neg_vref     = (neg_input_select == NEG_VREF);
      next_mux.neg_gnd      = (neg_input_select == NEG_GND);
      next_mux.differential = (neg_input_select != NEG_GND);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mux_ctrl <= '0;
      end else begin
         mux_ctrl <= next_mux;
      end
   end

   // ==========================================================
   // Analog power
   // Power follows the enable one clock late; shut down it draws nothing
   always_comb begin
      next_power = conv_enable;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         analog_power_on <= 1'b0;
      end else begin
         analog_power_on <= next_power;
      end
   end

endmodule

// *** sar_adc_sequencer_sva.sv ***
// Port-level assertion checker for the SAR sequencer
`timescale 1ns/1ps
module sar_adc_sequencer_sva
   import sar_adc_pkg::*;
#(
   parameter int RES_BITS = 10,
   parameter int DIV_W    = 5
) (
   input wire logic                   clk,
   input wire logic                   rst,
   input wire logic                   conv_enable,
   input wire logic                   lowpower_track_sel,
   input wire logic [DIV_W-1:0]       sar_clk_divider,
   input wire logic [2:0]             start_source_sel,
   input wire logic [4:0]             pos_input_select,
   input wire logic [4:0]             neg_input_select,
   input wire logic                   sw_start,
   input wire logic                   irq_enable,
   input wire logic                   standby_track_off,
   input wire logic                   track,
   input wire sar_adc_pkg::mux_ctrl_t mux_ctrl,
   input wire logic                   conv_in_progress,
   input wire logic                   conv_done_flag,
   input wire logic                   conv_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ====
   // Busy length, expected length frozen at the start edge
   int busy_cnt;
   int next_busy_cnt;
   int exp_len;
   int next_exp_len;
   always_comb begin
      next_busy_cnt = conv_in_progress ? busy_cnt + 1 : 0;
      next_exp_len  = conv_in_progress ? exp_len :
         (lowpower_track_sel && start_source_sel != 3'h4 ? 13 : 10) * (int'(sar_clk_divider) + 1);
   end
   always_ff @(posedge clk) begin
      busy_cnt <= rst ? 0 : next_busy_cnt;
      exp_len  <= next_exp_len;
   end
   // ====
   // Sequences
   sequence s_finish;
      $fell(conv_in_progress) && $past(conv_enable);
   endsequence
   sequence s_sw_start;
      conv_enable && !conv_in_progress && start_source_sel == 3'h0 && sw_start;
   endsequence
   // ====
   // Properties
   property p_off;
      !conv_enable |=> !conv_in_progress;
   endproperty
   property p_sw;
      s_sw_start |=> conv_in_progress;
   endproperty
   // Counts also catch a restart, since a second start would stretch busy
   property p_len;
      s_finish |-> busy_cnt == exp_len;
   endproperty
   property p_done;
      s_finish |-> conv_done_flag;
   endproperty
   property p_irq;
      !$past(rst) |-> conv_irq == (conv_done_flag && $past(irq_enable));
   endproperty
   property p_mode;
      !$past(rst) |-> mux_ctrl.differential == ($past(neg_input_select) != NEG_GND)
         && mux_ctrl.neg_gnd == ($past(neg_input_select) == NEG_GND);
   endproperty
   property p_codes;
      !$past(rst) |-> mux_ctrl.pos_temp == ($past(pos_input_select) == POS_TEMP_SENSOR)
         && mux_ctrl.pos_supply == ($past(pos_input_select) == POS_SUPPLY)
         && mux_ctrl.neg_vref == ($past(neg_input_select) == NEG_VREF);
   endproperty
   property p_hold;
      conv_in_progress && !lowpower_track_sel |-> !track;
   endproperty
   property p_resume;
      s_finish ##0 (!lowpower_track_sel && !$past(standby_track_off)) |-> track;
   endproperty
   property p_standby;
      !$past(rst) && $past(standby_track_off) |-> !track;
   endproperty
   a_off:     assert property (p_off) else $error("busy while disabled");
   a_sw:      assert property (p_sw) else $error("software start not taken");
   a_len:     assert property (p_len) else $error("busy length wrong");
   a_done:    assert property (p_done) else $error("flag not set at finish");
   a_irq:     assert property (p_irq) else $error("irq not flag and enable");
   a_mode:    assert property (p_mode) else $error("mode not from ground select");
   a_codes:   assert property (p_codes) else $error("select code decode wrong");
   a_hold:    assert property (p_hold) else $error("tracking during conversion");
   a_resume:  assert property (p_resume) else $error("tracking not resumed");
   a_standby: assert property (p_standby) else $error("tracking in standby");
endmodule

// *** sar_adc_sequencer_tb.sv ***
// Self-checking testbench for the SAR sequencer
`timescale 1ns/1ps
bind sar_adc_sequencer sar_adc_sequencer_sva #(.RES_BITS(RES_BITS), .DIV_W(DIV_W)) u_sva (.clk, .rst,
   .conv_enable, .lowpower_track_sel, .sar_clk_divider, .start_source_sel, .pos_input_select,
   .neg_input_select, .sw_start, .irq_enable, .standby_track_off, .track, .mux_ctrl, .conv_in_progress,
   .conv_done_flag, .conv_irq);
module sar_adc_sequencer_tb;
   import sar_adc_pkg::*;
   typedef struct packed {
      logic [1:0]  lp_lj;
      logic [4:0]  div, pos, neg;
      logic [2:0]  src;
      logic [9:0]  lvl;
      logic [15:0] res;
   } row_t;
   // ====
   // Signals
   logic        clk = 1'b0, rst = 1'b1, conv_enable = 1'b1, lowpower_track_sel = 1'b0;
   logic        left_justify_sel = 1'b0, done_clear = 1'b0, irq_enable = 1'b1, standby_track_off = 1'b0;
   logic [4:0]  sar_clk_divider = 5'h00, pos_input_select = 5'h00, neg_input_select = 5'h1f;
   logic [2:0]  start_source_sel = 3'h0;
   logic [5:0]  trig = 6'h00;
   logic [9:0]  level = 10'h000, dac_code;
   logic        analog_power_on, track, comp_in, conv_in_progress, conv_done_flag, conv_irq;
   logic [7:0]  result_high_byte, result_low_byte;
   mux_ctrl_t   mux_ctrl;
   timer_trig_t timer2, timer3;
   int          errors = 0, cmp_count = 0, cyc = 0, t0 = 0;
   // Both timers see both overflows; only the mode bit tells them apart
   assign timer2 = {trig[5], trig[2], 1'b0};
   assign timer3 = {trig[5], trig[2], 1'b1};
   sar_adc_sequencer dut (.clk, .rst, .conv_enable, .lowpower_track_sel, .left_justify_sel, .sar_clk_divider,
      .start_source_sel, .pos_input_select, .neg_input_select, .sw_start(trig[0]), .done_clear, .irq_enable,
      .standby_track_off, .timer0_ovf(trig[1]), .timer1_ovf(trig[3]), .timer2, .timer3,
      .ext_start_pin(trig[4]), .comp_in, .analog_power_on, .track, .dac_code, .mux_ctrl, .conv_in_progress,
      .conv_done_flag, .conv_irq, .result_high_byte, .result_low_byte);
   comparator_model model (.dac_code, .analog_power_on, .level, .comp_in);
   row_t rows [8] = '{
      '{2'b00, 5'h00, 5'h03, 5'h1f, 3'h0, 10'h3ff, 16'h03ff},
      '{2'b01, 5'h00, 5'h1e, 5'h1f, 3'h1, 10'h3ff, 16'hffc0},
      '{2'b00, 5'h00, 5'h1f, 5'h1e, 3'h2, 10'h3ff, 16'h01ff},
      '{2'b00, 5'h01, 5'h02, 5'h05, 3'h3, 10'h000, 16'hfe00},
      '{2'b01, 5'h00, 5'h04, 5'h1e, 3'h4, 10'h000, 16'h8000},
      '{2'b01, 5'h00, 5'h05, 5'h1e, 3'h5, 10'h3ff, 16'h7fc0},
      '{2'b10, 5'h02, 5'h06, 5'h1f, 3'h0, 10'h100, 16'h0100},
      '{2'b11, 5'h1f, 5'h07, 5'h1f, 3'h4, 10'h200, 16'h8000}
   };
   initial forever #10 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   // ====
   // Tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("compares=%0d mismatches=%0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic pulse(input logic [5:0] t);
      @(posedge clk) trig <= t;
      @(posedge clk) trig <= 6'h00;
   endtask
   task automatic setup(input logic [29:0] v);
      @(posedge clk) {lowpower_track_sel, left_justify_sel, sar_clk_divider, pos_input_select,
         neg_input_select, start_source_sel, level} <= v;
      done_clear <= 1'b1;
      @(posedge clk) done_clear <= 1'b0;
   endtask
   task automatic wait_done;
      int n;
      n = 0;
      while (conv_done_flag !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 2000) errors++;
   endtask
   // ====
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         setup({rows[i].lp_lj, rows[i].div, rows[i].pos, rows[i].neg, rows[i].src, rows[i].lvl});
         irq_enable <= i[0];
         pulse(6'h01 << rows[i].src);
         wait_done;
         chk({result_high_byte, result_low_byte}, rows[i].res);
         chk(16'(conv_irq), 16'(i[0]));
      end
      for (int s = 0; s < 8; s++) begin
         setup({2'b00, 5'h00, 5'h00, 5'h1f, 3'(s), 10'h0aa});
         pulse(6'h3f & ~(6'h01 << s));
         repeat (2) @(posedge clk);
         chk(16'(conv_in_progress), 16'h0000);
      end
      setup({2'b00, 5'h01, 5'h00, 5'h1f, 3'h0, 10'h155});
      pulse(6'h01);
      t0 = cyc;
      repeat (4) @(posedge clk);
      pulse(6'h01);
      wait_done;
      chk({result_high_byte, result_low_byte}, 16'h0155);
      chk(16'(cyc - t0), 16'h0015);
      repeat (3) @(posedge clk);
      chk({15'h0000, conv_in_progress}, 16'h0000);
      chk({15'h0000, track}, 16'h0001);
      setup({2'b00, 5'h01, 5'h00, 5'h1f, 3'h0, 10'h2aa});
      pulse(6'h01);
      repeat (3) @(posedge clk);
      conv_enable <= 1'b0;
      pulse(6'h01);
      repeat (2) @(posedge clk);
      chk({13'h0000, conv_in_progress, conv_done_flag, analog_power_on}, 16'h0000);
      chk({result_high_byte, result_low_byte}, 16'h0155);
      @(posedge clk) conv_enable <= 1'b1;
      standby_track_off <= 1'b1;
      repeat (5) @(posedge clk);
      chk({15'h0000, track}, 16'h0000);
      standby_track_off <= 1'b0;
      pulse(6'h01);
      repeat (3) @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      chk({result_high_byte, result_low_byte}, 16'h0000);
      chk({14'h0000, conv_in_progress, conv_done_flag}, 16'h0000);
      rst <= 1'b0;
      end_of_test;
   end
   // Whole run is under a thousand cycles; this margin only cuts a hang
   initial begin
      #400us;
      errors++;
      end_of_test;
   end
endmodule

// *** sar_clk_divider_gen.sv ***
// Conversion clock tick generator, system clock divided by divider plus one
`timescale 1ns/1ps
module sar_clk_divider_gen #(
   parameter int DIV_BITS = 5
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                restart,
   input  wire logic [DIV_BITS-1:0] divider,
   output logic                     tick
);
   logic [DIV_BITS-1:0] cnt;
   logic [DIV_BITS-1:0] next_cnt;

   // ==========================================================
   // Divider
   // Restart aligns the first tick to the start event, so every
   // conversion with the same divider and tracking window takes the same number of system clocks
   always_comb begin
      tick     = 1'b0;
      next_cnt = cnt + 1'b1;
      if (restart) begin
         next_cnt = '0;
      end else if (cnt >= divider) begin
         tick     = 1'b1;
         next_cnt = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end
endmodule
